// [design/rrlc_top.sv]
// Ring relay and general purpose relay latch control with ring-trip detection.
// Summary of operation
// - While gate is high the ring latch follows ring command; holds at gate fall.
// - A trip pulse forces the ring latch clear regardless of gate and command.
// - Ring relay flip-flop loads the ring latch only on sync rising edges.
// - Each general relay latch follows its command while gate high, holds after.
// - Sync rising edge opens a 20 us comparator window, then the average is dumped.
// - Average above 12 mA inside the window emits a trip pulse clearing the ring path.
`timescale 1ns/1ps
module rrlc_top
   import rrlc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Controller latch inputs
   input wire logic latch_gate,
   input wire logic ring_cmd,
   input wire logic relay_cmd_1,
   input wire logic relay_cmd_2,
   // Ring timing and loop current
   input wire logic zero_cross_sync,
   input wire logic [LEVEL_W-1:0] loop_level,
   // Relay driver outputs
   output logic ring_drive,
   output logic relay_drive_1,
   output logic relay_drive_2,
   // Trip observation
   output logic trip_pulse,
   output logic trip_window,
   output logic cap_discharge
);

   // ***********************************************
   // Input synchronisation
   // ***********************************************
   // Pins and the averaged level come from outside the clock domain. The level is
   // sampled only while steady inside the window, so per-bit skew is tolerable.
   localparam int unsigned NSYNC = 5 + LEVEL_W;
   logic [NSYNC-1:0] pins_raw;
   logic [NSYNC-1:0] pins_s;
   logic gate_s;
   logic ring_s;
   logic cmd1_s;
   logic cmd2_s;
   logic sync_s;
   logic [LEVEL_W-1:0] level_s;

   assign pins_raw = {latch_gate, ring_cmd, relay_cmd_1, relay_cmd_2, zero_cross_sync, loop_level};

   rrlc_sync2 #(.W(NSYNC)) u_sync (
      .mclk(mclk),
      .nrst(nrst),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );

   assign {gate_s, ring_s, cmd1_s, cmd2_s, sync_s, level_s} = pins_s;

   // ***********************************************
   // Sync edge detection
   // ***********************************************
   logic sync_d_reg;
   logic sync_d_next;
   logic sync_rise;

   assign sync_rise = sync_s & ~sync_d_reg;

   always_comb begin
      sync_d_next = nrst ? sync_s : 1'b0;
   end

   always_ff @(posedge mclk) begin
      sync_d_reg <= sync_d_next;
   end

   // ***********************************************
   // Trip window one-shot and comparator
   // ***********************************************
   rrlc_win_e win_reg;
   rrlc_win_e win_next;
   logic [WIN_CNT_W-1:0] wcnt_reg;
   logic [WIN_CNT_W-1:0] wcnt_next;
   logic trip_reg;
   logic trip_next;
   logic dump_reg;
   logic dump_next;
   logic open_reg;
   logic open_next;

   always_comb begin
      win_next = win_reg;
      wcnt_next = wcnt_reg;
      trip_next = 1'b0;
      case (win_reg)
         WIN_IDLE: begin
            wcnt_next = WIN_ZERO;
         end
         WIN_OPEN: begin
            if (level_s > TRIP_THRESHOLD) begin
               trip_next = 1'b1;
            end
            if (wcnt_reg == WIN_LAST) begin
               win_next = WIN_DUMP;
            end else begin
               wcnt_next = wcnt_reg + 10'h001;
            end
         end
         WIN_DUMP: begin
            win_next = WIN_IDLE;
         end
         default: begin
            win_next = WIN_IDLE;
         end
      endcase
      if (sync_rise) begin
         win_next = WIN_OPEN;
         wcnt_next = WIN_ZERO;
      end
      // A pulse is always followed by a quiet cycle, so each pulse stays one cycle wide.
      // While the level stays high the pulse repeats every other cycle until the window closes.
      if (trip_reg) begin
         trip_next = 1'b0;
      end
      open_next = (win_next == WIN_OPEN);
      dump_next = (win_next == WIN_DUMP);
      if (!nrst) begin
         win_next = WIN_IDLE;
         wcnt_next = WIN_ZERO;
         trip_next = 1'b0;
         open_next = 1'b0;
         dump_next = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      win_reg <= win_next;
      wcnt_reg <= wcnt_next;
      trip_reg <= trip_next;
      open_reg <= open_next;
      dump_reg <= dump_next;
   end

   // ***********************************************
   // Relay latches and ring flip-flop
   // ***********************************************
   rrlc_relay_s latch_reg;
   rrlc_relay_s latch_next;
   logic ring_ff_reg;
   logic ring_ff_next;

   always_comb begin
      latch_next = latch_reg;
      ring_ff_next = ring_ff_reg;
      if (gate_s) begin
         latch_next.ring = ring_s;
      end
      if (gate_s) begin
         latch_next.gp1 = cmd1_s;
         latch_next.gp2 = cmd2_s;
      end
      if (trip_reg) begin
         latch_next.ring = 1'b0;
      end
      // Load ring flip-flop on sync edge
      if (sync_rise) begin
         ring_ff_next = latch_reg.ring & ~trip_reg;
      end
      // The trip pulse resets the ring driver flip-flop directly.
      // Trip clears ring flip-flop
      if (trip_reg) begin
         ring_ff_next = 1'b0;
      end
      if (!nrst) begin
         latch_next = RELAY_CLEAR;
         ring_ff_next = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      latch_reg <= latch_next;
      ring_ff_reg <= ring_ff_next;
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   // Drivers follow their storage
   assign ring_drive = ring_ff_reg;
   assign relay_drive_1 = latch_reg.gp1;
   assign relay_drive_2 = latch_reg.gp2;
   assign trip_pulse = trip_reg;
   assign trip_window = open_reg;
   assign cap_discharge = dump_reg;

   // ***********************************************
   // Checks
   // ***********************************************
   chk_gate_ring_follow: assert property (@(posedge mclk) disable iff (!nrst)
      gate_s && !trip_reg && !trip_next |=> latch_reg.ring == $past(ring_s))
      else $error("Ring latch did not follow command while gate high.");

   chk_ring_hold: assert property (@(posedge mclk) disable iff (!nrst)
      !gate_s && !trip_reg |=> latch_reg.ring == $past(latch_reg.ring))
      else $error("Ring latch changed while gate low.");

   chk_trip_clears_latch: assert property (@(posedge mclk) disable iff (!nrst)
      trip_reg |=> !latch_reg.ring && !ring_drive)
      else $error("Trip pulse did not clear ring path.");

   chk_ring_ff_edge: assert property (@(posedge mclk) disable iff (!nrst)
      !sync_rise |=> ring_drive == 1'b0 || $stable(ring_drive))
      else $error("Ring flip-flop set without sync edge.");

   chk_ring_ff_load: assert property (@(posedge mclk) disable iff (!nrst)
      sync_rise && !trip_reg |=> ring_drive == $past(latch_reg.ring))
      else $error("Ring flip-flop did not load latch at sync edge.");

   chk_gp_follow: assert property (@(posedge mclk) disable iff (!nrst)
      gate_s |=> relay_drive_1 == $past(cmd1_s) && relay_drive_2 == $past(cmd2_s))
      else $error("General relay latch did not follow command.");

   chk_gp_hold: assert property (@(posedge mclk) disable iff (!nrst)
      !gate_s |=> $stable(relay_drive_1) && $stable(relay_drive_2))
      else $error("General relay latch changed while gate low.");

   chk_window_open: assert property (@(posedge mclk) disable iff (!nrst)
      sync_rise |=> trip_window && win_reg == WIN_OPEN)
      else $error("Sync edge did not open trip window.");

   chk_window_dump: assert property (@(posedge mclk) disable iff (!nrst)
      win_reg == WIN_OPEN && wcnt_reg == WIN_LAST && !sync_rise |=> cap_discharge ##1 !cap_discharge)
      else $error("Window end did not discharge averaging capacitor for one cycle.");

   chk_trip_cause: assert property (@(posedge mclk) disable iff (!nrst)
      trip_pulse |-> $past(win_reg == WIN_OPEN) && $past(level_s) > TRIP_THRESHOLD)
      else $error("Trip pulse without level above threshold in window.");

   chk_trip_single: assert property (@(posedge mclk) disable iff (!nrst)
      trip_pulse |=> !trip_pulse)
      else $error("Trip pulse lasted longer than one cycle.");

endmodule

// [inc/rrlc_pkg.sv]
// Package with constants and carrier types for the ring relay latch control block.
package rrlc_pkg;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int unsigned CLK_PERIOD_NS = 25;
   // Comparator enable window after each sync rising edge, in microseconds.
   localparam int unsigned TRIP_WINDOW_US = 20;
   localparam int unsigned TRIP_WINDOW_CYC = (TRIP_WINDOW_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned WIN_CNT_W = 10;
   localparam logic [WIN_CNT_W-1:0] WIN_LAST = WIN_CNT_W'(TRIP_WINDOW_CYC - 1);
   localparam logic [WIN_CNT_W-1:0] WIN_ZERO = 10'h000;

   // ***********************************************
   // Loop current level
   // ***********************************************
   // Averaged loop current arrives as a digital code in units of 0.1 mA.
   localparam int unsigned LEVEL_W = 12;
   localparam logic [LEVEL_W-1:0] TRIP_THRESHOLD = 12'h0078;
   localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 12'h0000;

   // ***********************************************
   // Carriers
   // ***********************************************
   typedef struct packed {
      logic ring;
      logic gp1;
      logic gp2;
   } rrlc_relay_s;

   localparam rrlc_relay_s RELAY_CLEAR = '{ring: 1'b0, gp1: 1'b0, gp2: 1'b0};

   typedef enum logic [1:0] {
      WIN_IDLE = 2'b00,
      WIN_OPEN = 2'b01,
      WIN_DUMP = 2'b11
   } rrlc_win_e;

endpackage

// [design/rrlc_sync2.sv]
// Two-stage synchroniser for asynchronous input pins.
`timescale 1ns/1ps
module rrlc_sync2 #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Data
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] sync_reg;
   logic [W-1:0] sync_next;

   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
      if (!nrst) begin
         meta_next = '0;
         sync_next = '0;
      end
   end

   always_ff @(posedge mclk) begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
   end

   assign sync_out = sync_reg;

endmodule

// [test/rrlc_ctrl_model.sv]
// Line card controller model driving the latch, sync and loop level pins.
`timescale 1ns/1ps
module rrlc_ctrl_model
   import rrlc_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Controller pins
   output logic latch_gate,
   output logic ring_cmd,
   output logic relay_cmd_1,
   output logic relay_cmd_2,
   output logic zero_cross_sync,
   output logic [LEVEL_W-1:0] loop_level
);
   initial begin
      {latch_gate, ring_cmd, relay_cmd_1, relay_cmd_2, zero_cross_sync} = 5'h00;
      loop_level = LEVEL_ZERO;
   end

   task automatic load(input logic ring, input logic c1, input logic c2);
      @(negedge mclk);
      {ring_cmd, relay_cmd_1, relay_cmd_2} = {ring, c1, c2};
      latch_gate = 1'b1;
      repeat (4) @(negedge mclk);
      latch_gate = 1'b0;
      repeat (4) @(negedge mclk);
      // Commands flip while the gate is low, so a leaky latch shows up.
      {ring_cmd, relay_cmd_1, relay_cmd_2} = {~ring, ~c1, ~c2};
      repeat (4) @(negedge mclk);
   endtask

   task automatic sync_rise(input logic [LEVEL_W-1:0] lvl);
      @(negedge mclk);
      loop_level = lvl;
      zero_cross_sync = 1'b1;
   endtask

   // The level falls back once the averaging capacitor has been dumped.
   task automatic sync_fall();
      @(negedge mclk);
      zero_cross_sync = 1'b0;
      loop_level = LEVEL_ZERO;
      repeat (4) @(negedge mclk);
   endtask
endmodule

// [test/rrlc_top_tb_top.sv]
// Self-checking testbench for the ring relay latch control block.
`timescale 1ns/1ps
module rrlc_top_tb_top
   import rrlc_pkg::*;
;
   logic mclk;
   logic nrst;
   logic latch_gate, ring_cmd, relay_cmd_1, relay_cmd_2, zero_cross_sync;
   logic [LEVEL_W-1:0] loop_level;
   logic ring_drive, relay_drive_1, relay_drive_2, trip_pulse, trip_window, cap_discharge;
   int n_fail = 0;
   int samples_checked = 0;

   rrlc_ctrl_model rrlc_ctrl_model_i (.mclk(mclk), .latch_gate(latch_gate), .ring_cmd(ring_cmd),
      .relay_cmd_1(relay_cmd_1), .relay_cmd_2(relay_cmd_2), .zero_cross_sync(zero_cross_sync),
      .loop_level(loop_level));

   rrlc_top rrlc_top_i (.mclk(mclk), .nrst(nrst), .latch_gate(latch_gate), .ring_cmd(ring_cmd),
      .relay_cmd_1(relay_cmd_1), .relay_cmd_2(relay_cmd_2), .zero_cross_sync(zero_cross_sync),
      .loop_level(loop_level), .ring_drive(ring_drive), .relay_drive_1(relay_drive_1),
      .relay_drive_2(relay_drive_2), .trip_pulse(trip_pulse), .trip_window(trip_window),
      .cap_discharge(cap_discharge));

   initial begin
      mclk = 1'b0;
      forever #(CLK_PERIOD_NS / 2.0) mclk = ~mclk;
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One sync edge; measures the window and judges the ring driver after it.
   task automatic run_ring(input logic [LEVEL_W-1:0] lvl, input logic exp_ring, input logic exp_trip);
      int n;
      logic tripped;
      logic dumped;
      n = 0;
      tripped = 1'b0;
      dumped = 1'b0;
      rrlc_ctrl_model_i.sync_rise(lvl);
      while (trip_window !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      n = 0;
      do begin
         tripped |= (trip_pulse === 1'b1);
         @(negedge mclk);
         n++;
      end while (trip_window === 1'b1 && n < 1000);
      repeat (2) begin
         dumped |= (cap_discharge === 1'b1);
         @(negedge mclk);
      end
      chk("window length", 16'(TRIP_WINDOW_CYC), 16'(n));
      chk("capacitor dump", 16'h0001, {15'h0000, dumped});
      chk("trip pulse", {15'h0000, exp_trip}, {15'h0000, tripped});
      chk("ring drive", {15'h0000, exp_ring}, {15'h0000, ring_drive});
      rrlc_ctrl_model_i.sync_fall();
   endtask

   task automatic gp_relays();
      rrlc_ctrl_model_i.load(1'b0, 1'b1, 1'b0);
      chk("general drives a", 16'h0002, {14'h0000, relay_drive_1, relay_drive_2});
      rrlc_ctrl_model_i.load(1'b0, 1'b0, 1'b1);
      chk("general drives b", 16'h0001, {14'h0000, relay_drive_1, relay_drive_2});
   endtask

   task automatic ring_path();
      rrlc_ctrl_model_i.load(1'b1, 1'b0, 1'b0);
      chk("ring before sync", 16'h0000, {15'h0000, ring_drive});
      run_ring(LEVEL_ZERO, 1'b1, 1'b0);
      rrlc_ctrl_model_i.load(1'b0, 1'b0, 1'b0);
      chk("ring between syncs", 16'h0001, {15'h0000, ring_drive});
      run_ring(LEVEL_ZERO, 1'b0, 1'b0);
   endtask

   task automatic ring_trip();
      rrlc_ctrl_model_i.load(1'b1, 1'b0, 1'b0);
      run_ring(TRIP_THRESHOLD, 1'b1, 1'b0);
      run_ring(TRIP_THRESHOLD + 12'h0001, 1'b0, 1'b1);
      // A cleared latch keeps the relay off at the following sync edge.
      run_ring(LEVEL_ZERO, 1'b0, 1'b0);
   endtask

   initial begin
      nrst = 1'b0;
      repeat (10) @(negedge mclk);
      nrst = 1'b1;
      @(negedge mclk);
      chk("outputs after reset", 16'h0000, {10'h000, ring_drive, relay_drive_1, relay_drive_2,
         trip_pulse, trip_window, cap_discharge});
      gp_relays();
      ring_path();
      ring_trip();
      tally_and_finish();
   end

   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      tally_and_finish();
   end
endmodule
